/* File: rsdpc_pkg.sv */
/*
  Shared constants for the resolver decoder program control block: slot
  register map, parameter ranges and reset values, key and status bit
  positions, reply codes and the panel screen encoding.
  Assumes every consumer refers to names as rsdpc_pkg::name.
*/
package rsdpc_pkg;

  // Slot register map, as byte addresses of 16-bit words
  localparam logic [15:0] ADDR_SPEED     = 16'h0080;
  localparam logic [15:0] ADDR_ANGLE     = 16'h0082;
  localparam logic [15:0] ADDR_COND      = 16'h0084;
  localparam logic [15:0] ADDR_SCALE     = 16'h0102;
  localparam logic [15:0] ADDR_SHIFT     = 16'h0104;
  localparam logic [15:0] ADDR_WIN_UPPER = 16'h0106;
  localparam logic [15:0] ADDR_WIN_LOWER = 16'h0108;

  // Parameter ranges and reset values
  localparam logic [15:0] SCALE_MIN      = 16'h0013;  // 19
  localparam logic [15:0] SCALE_MAX      = 16'h0fff;  // 4095
  localparam logic [15:0] SCALE_RESET    = 16'h0167;  // 359, degree units
  localparam logic [15:0] SHIFT_RESET    = 16'h0000;
  localparam logic [15:0] LIMIT_MIN      = 16'h0000;
  localparam logic [15:0] LIMIT_MAX      = 16'h07cf;  // 1999 rpm
  localparam logic [15:0] UPPER_RESET    = 16'h07cf;
  localparam logic [15:0] LOWER_RESET    = 16'h0000;
  localparam logic [15:0] STILL_RPM      = 16'h0003;  // scale and shift edits refused above this

  // Key vector bit positions
  localparam int KEY_MODE   = 0;
  localparam int KEY_INC    = 1;
  localparam int KEY_DEC    = 2;
  localparam int KEY_RIGHT  = 3;
  localparam int KEY_RECALL = 4;
  localparam int KEY_W      = 5;

  // Condition word bit positions
  localparam int COND_MOTION = 0;
  localparam int COND_DIR    = 1;
  localparam int COND_CABLE  = 2;
  localparam int COND_DIAG   = 3;
  localparam int COND_PERMIT = 4;

  // Reply status codes
  localparam logic [1:0] RPL_OK     = 2'h0;
  localparam logic [1:0] RPL_RANGE  = 2'h1;
  localparam logic [1:0] RPL_MOVING = 2'h2;
  localparam logic [1:0] RPL_BADREG = 2'h3;

  // Panel screens, one-hot
  typedef enum logic [4:0] {
    SCR_DEFAULT = 5'h01,
    SCR_SCALE   = 5'h02,
    SCR_SHIFT   = 5'h04,
    SCR_LIMITS  = 5'h08,
    SCR_FAULT   = 5'h10
  } rsdpc_screen_e;

endpackage

/* File: rsdpc_top.sv */
/*
  Program control for a single-turn resolver decoder module: slot command
  port with reply, parameter store, position scaling and zero shift, speed
  window output, front panel screen sequencer with timeout, and fault mode.
  Assumes the converter supplies RAW_POS_I and SPEED_I on MCLK_I, the slot
  command strobe is synchronous to MCLK_I, and panel keys and field inputs
  are asynchronous pins (already debounced).
*/
`timescale 1ns/1ps
module rsdpc_top #(
  parameter int          POS_W      = 12,     // Converter position width
  parameter int unsigned TIMEOUT_MS = 30000,  // Panel idle timeout
  parameter int unsigned CLK_KHZ    = 250000  // MCLK_I rate
) (
  input  wire logic        MCLK_I,        // Module clock
  input  wire logic        RST_I,         // Async reset, high
  input  wire logic        CMD_STB_I,     // Slot command strobe
  input  wire logic        CMD_WR_I,      // 1 write, 0 read
  input  wire logic [15:0] CMD_ADDR_I,    // Register address
  input  wire logic [15:0] CMD_DATA_I,    // Write value
  output logic             RPL_VALID_O,   // Reply pulse
  output logic [15:0]      RPL_DATA_O,    // Read value or echoed write value
  output logic [1:0]       RPL_STATUS_O,  // Reply status code
  input  wire logic [POS_W-1:0] RAW_POS_I, // Converter position
  input  wire logic [15:0] SPEED_I,       // Shaft speed, rpm
  input  wire logic        DIR_I,         // 1 counterclockwise
  input  wire logic [4:0]  KEYS_I,        // Panel keys, pin level
  input  wire logic        PERMIT_I,      // Programming permit pin
  input  wire logic        QUAL_I,        // Mode advance qualifier pin
  input  wire logic        CPU_FAULT_I,   // Processor fault pin
  input  wire logic        PWR_FAULT_I,   // Power fault pin
  input  wire logic        CABLE_FAULT_I, // Cable fault pin
  output logic             MOTION_O,      // Speed inside window
  output logic             HEALTHY_O,     // Fail-safe, high when healthy
  output logic [4:0]       SCREEN_O,      // Current screen, one-hot
  output logic [15:0]      DISP_POS_O,    // Position field
  output logic [15:0]      DISP_AUX_O,    // Speed field, value of the current edit screen, or zero in the fault screen
  output logic             CURSOR_O,      // Limits cursor on value
  output logic             LIM_SEL_O      // 1 upper limit selected
);

  // 30 s at 250 MHz overflows 32 bits
  localparam logic [39:0] TIMEOUT_CYC = 40'(64'(TIMEOUT_MS) * 64'(CLK_KHZ));

  // Step within [lo,hi], holding at the ends
  function automatic logic [15:0] step(input logic [15:0] v, input logic up,
                                      input logic [15:0] lo, input logic [15:0] hi);
    if (up) begin
      step = (v >= hi) ? hi : v + 16'h0001;
    end else begin
      step = (v <= lo) ? lo : v - 16'h0001;
    end
  endfunction

  // Synchronisers: first stage read only by the second
  // Keys, permit, qualifier, then the fault pins
  logic [9:0] pin_s1_reg;
  logic [9:0] pin_s2_reg;
  logic [4:0] key_prev_reg;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_reg   <= '0;
      pin_s2_reg   <= '0;
      key_prev_reg <= '0;
    end else begin
      pin_s1_reg   <= {CABLE_FAULT_I, PWR_FAULT_I, CPU_FAULT_I, QUAL_I, PERMIT_I, KEYS_I};
      pin_s2_reg   <= pin_s1_reg;
      key_prev_reg <= pin_s2_reg[4:0];
    end
  end

  logic [4:0] press;
  logic       permit;
  logic       qual;
  logic       fault;
  logic       moving;
  always_comb begin
    press  = pin_s2_reg[4:0] & ~key_prev_reg;
    permit = pin_s2_reg[5];
    qual   = pin_s2_reg[6];
    fault  = |pin_s2_reg[9:7];
    moving = SPEED_I > rsdpc_pkg::STILL_RPM;
  end

  // Parameter store, screen sequencer and slot replies
  rsdpc_pkg::rsdpc_screen_e scr_reg, scr_next, ret_reg, ret_next;
  logic [15:0] scale_reg, scale_next;
  logic [15:0] shift_reg, shift_next;
  logic [15:0] upper_reg, upper_next;
  logic [15:0] lower_reg, lower_next;
  logic [39:0] idle_reg, idle_next;
  logic        cursor_reg, cursor_next;
  logic        sel_reg, sel_next;
  logic        rv_reg, rv_next;
  logic [15:0] rd_reg, rd_next;
  logic [1:0]  rs_reg, rs_next;
  logic [15:0] cond;
  logic [15:0] angle_reg;

  // Condition word
  always_comb begin
    cond = '0;
    cond[rsdpc_pkg::COND_MOTION] = MOTION_O;
    cond[rsdpc_pkg::COND_DIR]    = DIR_I;
    cond[rsdpc_pkg::COND_CABLE]  = pin_s2_reg[9];
    cond[rsdpc_pkg::COND_DIAG]   = fault;
    cond[rsdpc_pkg::COND_PERMIT] = permit;
  end

  // Next-value logic
  always_comb begin
    scr_next    = scr_reg;
    ret_next    = ret_reg;
    scale_next  = scale_reg;
    shift_next  = shift_reg;
    upper_next  = upper_reg;
    lower_next  = lower_reg;
    idle_next   = idle_reg;
    cursor_next = cursor_reg;
    sel_next    = sel_reg;
    rv_next     = 1'b0;
    rd_next     = rd_reg;
    rs_next     = rs_reg;

    // Panel: keys reset the idle count; recall is never decoded
    // Keys are dropped while faulted
    if (scr_reg == rsdpc_pkg::SCR_FAULT) begin
      idle_next = '0;
      if (!fault) begin
        scr_next = ret_reg;
      end
    end else if (fault) begin
      ret_next  = scr_reg;
      scr_next  = rsdpc_pkg::SCR_FAULT;
    end else begin
      idle_next = (|press[3:0]) ? '0 : idle_reg + 40'h1;
      if (scr_reg != rsdpc_pkg::SCR_DEFAULT && idle_reg >= TIMEOUT_CYC - 40'h1) begin
        scr_next = rsdpc_pkg::SCR_DEFAULT;
      end else begin
        case (scr_reg)
          rsdpc_pkg::SCR_DEFAULT: begin
            if (press[rsdpc_pkg::KEY_MODE] && permit) begin
              scr_next = rsdpc_pkg::SCR_SCALE;
            end
          end
          rsdpc_pkg::SCR_SCALE: begin
            if (press[rsdpc_pkg::KEY_MODE]) begin
              if (qual) begin
                scr_next = rsdpc_pkg::SCR_SHIFT;
              end
            end else if ((press[rsdpc_pkg::KEY_INC] || press[rsdpc_pkg::KEY_DEC])
                         && permit && !moving) begin
              scale_next = step(scale_reg, press[rsdpc_pkg::KEY_INC],
                                rsdpc_pkg::SCALE_MIN, rsdpc_pkg::SCALE_MAX);
              // Keep the shift within the new scale
              if (shift_reg > scale_next) begin
                shift_next = scale_next;
              end
            end
          end
          rsdpc_pkg::SCR_SHIFT: begin
            if (press[rsdpc_pkg::KEY_MODE]) begin
              scr_next    = rsdpc_pkg::SCR_LIMITS;
              cursor_next = 1'b0;
            end else if ((press[rsdpc_pkg::KEY_INC] || press[rsdpc_pkg::KEY_DEC])
                         && permit && !moving) begin
              shift_next = step(shift_reg, press[rsdpc_pkg::KEY_INC],
                                rsdpc_pkg::SHIFT_RESET, scale_reg);
            end
          end
          rsdpc_pkg::SCR_LIMITS: begin
            if (press[rsdpc_pkg::KEY_MODE]) begin
              scr_next = rsdpc_pkg::SCR_DEFAULT;
            end else if (press[rsdpc_pkg::KEY_RIGHT]) begin
              cursor_next = ~cursor_reg;
            end else if ((press[rsdpc_pkg::KEY_INC] || press[rsdpc_pkg::KEY_DEC]) && permit) begin
              // Limits may change while turning
              if (!cursor_reg) begin
                sel_next = ~sel_reg;
              end else if (sel_reg) begin
                upper_next = step(upper_reg, press[rsdpc_pkg::KEY_INC],
                                  rsdpc_pkg::LIMIT_MIN, rsdpc_pkg::LIMIT_MAX);
              end else begin
                lower_next = step(lower_reg, press[rsdpc_pkg::KEY_INC],
                                  rsdpc_pkg::LIMIT_MIN, rsdpc_pkg::LIMIT_MAX);
              end
            end
          end
          default: scr_next = rsdpc_pkg::SCR_DEFAULT;
        endcase
      end
    end

    // Slot command: one action, one reply the next cycle; a command
    // in the same cycle as a panel step wins since it is applied last
    if (CMD_STB_I) begin
      rv_next = 1'b1;
      rs_next = rsdpc_pkg::RPL_OK;
      if (!CMD_WR_I) begin
        // Reads change no state
        case (CMD_ADDR_I)
          rsdpc_pkg::ADDR_SPEED:     rd_next = SPEED_I;
          rsdpc_pkg::ADDR_ANGLE:     rd_next = angle_reg;
          rsdpc_pkg::ADDR_COND:      rd_next = cond;
          rsdpc_pkg::ADDR_SCALE:     rd_next = scale_reg;
          rsdpc_pkg::ADDR_SHIFT:     rd_next = shift_reg;
          rsdpc_pkg::ADDR_WIN_UPPER: rd_next = upper_reg;
          rsdpc_pkg::ADDR_WIN_LOWER: rd_next = lower_reg;
          default: begin
            rd_next = '0;
            rs_next = rsdpc_pkg::RPL_BADREG;
          end
        endcase
      end else begin
        rd_next = CMD_DATA_I;
        // Refused writes echo data, change nothing
        case (CMD_ADDR_I)
          rsdpc_pkg::ADDR_SCALE: begin
            if (moving) begin
              rs_next = rsdpc_pkg::RPL_MOVING;
            end else if (CMD_DATA_I < rsdpc_pkg::SCALE_MIN || CMD_DATA_I > rsdpc_pkg::SCALE_MAX) begin
              rs_next = rsdpc_pkg::RPL_RANGE;
            end else begin
              scale_next = CMD_DATA_I;
              if (shift_next > CMD_DATA_I) begin
                shift_next = CMD_DATA_I;
              end
            end
          end
          rsdpc_pkg::ADDR_SHIFT: begin
            if (moving) begin
              rs_next = rsdpc_pkg::RPL_MOVING;
            end else if (CMD_DATA_I > scale_next) begin
              rs_next = rsdpc_pkg::RPL_RANGE;
            end else begin
              shift_next = CMD_DATA_I;
            end
          end
          rsdpc_pkg::ADDR_WIN_UPPER: begin
            if (CMD_DATA_I > rsdpc_pkg::LIMIT_MAX) begin
              rs_next = rsdpc_pkg::RPL_RANGE;
            end else begin
              upper_next = CMD_DATA_I;
            end
          end
          rsdpc_pkg::ADDR_WIN_LOWER: begin
            if (CMD_DATA_I > rsdpc_pkg::LIMIT_MAX) begin
              rs_next = rsdpc_pkg::RPL_RANGE;
            end else begin
              lower_next = CMD_DATA_I;
            end
          end
          default: rs_next = rsdpc_pkg::RPL_BADREG;
        endcase
      end
    end
  end

  // State registers
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scr_reg    <= rsdpc_pkg::SCR_DEFAULT;
      ret_reg    <= rsdpc_pkg::SCR_DEFAULT;
      scale_reg  <= rsdpc_pkg::SCALE_RESET;
      shift_reg  <= rsdpc_pkg::SHIFT_RESET;
      upper_reg  <= rsdpc_pkg::UPPER_RESET;
      lower_reg  <= rsdpc_pkg::LOWER_RESET;
      idle_reg   <= '0;
      cursor_reg <= 1'b0;
      sel_reg    <= 1'b1;
      rv_reg     <= 1'b0;
      rd_reg     <= '0;
      rs_reg     <= rsdpc_pkg::RPL_OK;
    end else begin
      scr_reg    <= scr_next;
      ret_reg    <= ret_next;
      scale_reg  <= scale_next;
      shift_reg  <= shift_next;
      upper_reg  <= upper_next;
      lower_reg  <= lower_next;
      idle_reg   <= idle_next;
      cursor_reg <= cursor_next;
      sel_reg    <= sel_next;
      rv_reg     <= rv_next;
      rd_reg     <= rd_next;
      rs_reg     <= rs_next;
    end
  end

  // Position path: scale raw angle to counts, add shift, wrap.
  // Two-cycle latency keeps the multiply off the wrap compare.
  logic [15:0] scaled_reg, scaled_next;
  logic [15:0] angle_next;
  logic [31:0] prod;
  logic [16:0] sum;
  always_comb begin
    prod        = 32'(RAW_POS_I) * 32'({16'h0000, scale_reg} + 32'h1);
    scaled_next = prod[POS_W+15:POS_W];
    sum         = {1'b0, scaled_reg} + {1'b0, shift_reg};
    if (sum > {1'b0, scale_reg}) begin
      angle_next = 16'(sum - ({1'b0, scale_reg} + 17'h00001));
    end else begin
      angle_next = sum[15:0];
    end
  end

  // Output group, all registered; fault forces outputs off
  logic        motion_next;
  logic [15:0] aux_next;
  always_comb begin
    motion_next = !fault && SPEED_I >= lower_reg && SPEED_I <= upper_reg;
    case (scr_reg)
      rsdpc_pkg::SCR_SCALE:  aux_next = scale_reg;
      rsdpc_pkg::SCR_SHIFT:  aux_next = shift_reg;
      rsdpc_pkg::SCR_LIMITS: aux_next = sel_reg ? upper_reg : lower_reg;
      rsdpc_pkg::SCR_FAULT:  aux_next = '0;
      default:               aux_next = SPEED_I;
    endcase
  end

  // Output and position registers
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scaled_reg <= '0;
      angle_reg  <= '0;
      MOTION_O   <= 1'b0;
      HEALTHY_O  <= 1'b0;
      DISP_AUX_O <= '0;
    end else begin
      scaled_reg <= scaled_next;
      angle_reg  <= angle_next;
      MOTION_O   <= motion_next;
      HEALTHY_O  <= !fault;
      DISP_AUX_O <= aux_next;
    end
  end

  // Register copies, no logic after the flops
  assign RPL_VALID_O  = rv_reg;
  assign RPL_DATA_O   = rd_reg;
  assign RPL_STATUS_O = rs_reg;
  assign SCREEN_O     = scr_reg;
  assign DISP_POS_O   = angle_reg;
  assign CURSOR_O     = cursor_reg;
  assign LIM_SEL_O    = sel_reg;

endmodule

/* File: rsdpc_checker.sv */
/*
  Port checker for rsdpc_top: reply timing and codes, fault outputs, reset screen.
  Assumes it is bound to every rsdpc_top instance and sees only its ports.
*/
`timescale 1ns/1ps
module rsdpc_checker (
  input  wire logic        MCLK_I,        // Module clock
  input  wire logic        RST_I,         // Async reset, high
  input  wire logic        CMD_STB_I,     // Command strobe
  input  wire logic        CMD_WR_I,      // Write flag
  input  wire logic [15:0] CMD_ADDR_I,    // Register address
  input  wire logic [15:0] CMD_DATA_I,    // Write value
  input  wire logic [15:0] SPEED_I,       // Shaft speed
  input  wire logic        CABLE_FAULT_I, // Cable fault pin
  input  wire logic        RPL_VALID_O,   // Reply pulse
  input  wire logic [1:0]  RPL_STATUS_O,  // Reply code
  input  wire logic        MOTION_O,      // Motion output
  input  wire logic        HEALTHY_O,     // Fail-safe output
  input  wire logic [4:0]  SCREEN_O       // Screen
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  // Write decode; speed test only matters for scale and shift
  logic wr_ro;
  logic wr_scale;
  logic wr_shift;
  logic wr_lim;
  assign wr_ro    = CMD_STB_I && CMD_WR_I && (CMD_ADDR_I inside {16'h0080, 16'h0082, 16'h0084});
  assign wr_scale = CMD_STB_I && CMD_WR_I && CMD_ADDR_I == rsdpc_pkg::ADDR_SCALE;
  assign wr_shift = CMD_STB_I && CMD_WR_I && CMD_ADDR_I == rsdpc_pkg::ADDR_SHIFT;
  assign wr_lim   = CMD_STB_I && CMD_WR_I && (CMD_ADDR_I inside {16'h0106, 16'h0108});

  a_reply_follows_cmd: assert property (CMD_STB_I |=> RPL_VALID_O)
    else $error("no reply one cycle after command");
  a_reply_has_cause: assert property (RPL_VALID_O |-> $past(CMD_STB_I))
    else $error("reply without a command");
  a_readonly_refused: assert property (wr_ro |=> RPL_STATUS_O == rsdpc_pkg::RPL_BADREG)
    else $error("write to read-only word not refused");
  a_scale_range_code: assert property (wr_scale && SPEED_I <= 16'h0003 |=> RPL_STATUS_O ==
    (($past(CMD_DATA_I) < 16'h0013 || $past(CMD_DATA_I) > 16'h0fff) ? rsdpc_pkg::RPL_RANGE : rsdpc_pkg::RPL_OK))
    else $error("scale write code wrong");
  a_moving_refused: assert property ((wr_scale || wr_shift) && SPEED_I > 16'h0003
    |=> RPL_STATUS_O == rsdpc_pkg::RPL_MOVING)
    else $error("edit accepted while turning");
  a_limit_range_code: assert property (wr_lim && CMD_DATA_I > 16'h07cf
    |=> RPL_STATUS_O == rsdpc_pkg::RPL_RANGE)
    else $error("limit above range accepted");
  a_fault_outputs_off: assert property (SCREEN_O == rsdpc_pkg::SCR_FAULT |-> !HEALTHY_O && !MOTION_O)
    else $error("outputs live in fault screen");
  a_fault_entry_bound: assert property (CABLE_FAULT_I [*6] |-> SCREEN_O == rsdpc_pkg::SCR_FAULT)
    else $error("fault screen not entered");
  a_reset_default_scr: assert property ($fell(RST_I) |-> SCREEN_O == rsdpc_pkg::SCR_DEFAULT)
    else $error("not in default screen after reset");
endmodule

bind rsdpc_top rsdpc_checker i_rsdpc_checker (.MCLK_I(MCLK_I), .RST_I(RST_I), .CMD_STB_I(CMD_STB_I),
  .CMD_WR_I(CMD_WR_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I), .SPEED_I(SPEED_I),
  .CABLE_FAULT_I(CABLE_FAULT_I), .RPL_VALID_O(RPL_VALID_O), .RPL_STATUS_O(RPL_STATUS_O),
  .MOTION_O(MOTION_O), .HEALTHY_O(HEALTHY_O), .SCREEN_O(SCREEN_O));

/* File: rsdpc_plc_model.sv */
/*
  Backplane controller model: issues one slot command at a time.
  Assumes its caller runs just after a rising clock edge.
*/
`timescale 1ns/1ps
module rsdpc_plc_model (
  input  wire logic        clk_i,  // Module clock
  output logic             stb_o,  // Command strobe
  output logic             wr_o,   // Write flag
  output logic [15:0]      addr_o, // Register address
  output logic [15:0]      data_o  // Write value
);
  initial begin
    stb_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'h0000;
    data_o = 16'h0000;
  end

  // One strobe, one action; bus shows the inverse once released so stale values never pass
  task automatic command(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk_i);
    #1;
    stb_o = 1'b1;
    wr_o = wr;
    addr_o = addr;
    data_o = data;
    @(posedge clk_i);
    #1;
    stb_o = 1'b0;
    wr_o = ~wr;
    addr_o = ~addr;
    data_o = ~data;
  endtask
endmodule

/* File: rsdpc_top_test.sv */
/*
  Self-checking bench for rsdpc_top: slot commands with queued replies, position, motion window,
  panel screens, timeout and fault. Assumes a 10-cycle idle timeout from the parameters set below.
*/
`timescale 1ns/1ps
module rsdpc_top_test;
  logic        MCLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        CMD_STB_I, CMD_WR_I, RPL_VALID_O, MOTION_O, HEALTHY_O, CURSOR_O, LIM_SEL_O;
  logic [15:0] CMD_ADDR_I, CMD_DATA_I, RPL_DATA_O, DISP_POS_O, DISP_AUX_O, lo, hi, s;
  logic [15:0] SPEED_I = 16'h0000;
  logic [11:0] RAW_POS_I = 12'h000;
  logic [4:0]  KEYS_I = 5'h00;
  logic [4:0]  SCREEN_O;
  logic [1:0]  RPL_STATUS_O;
  logic        DIR_I = 1'b0, PERMIT_I = 1'b0, QUAL_I = 1'b0, CABLE_FAULT_I = 1'b0, CPU_FAULT_I = 1'b0, PWR_FAULT_I = 1'b0;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  logic [17:0] expq[$]; // Expected {status, data} of each pending reply
  logic [15:0] sv[5] = '{16'h0012, 16'h1000, 16'h0013, 16'h0fff, 16'h03e7};

  always #2 MCLK_I = ~MCLK_I;

  rsdpc_plc_model i_rsdpc_plc_model (.clk_i(MCLK_I), .stb_o(CMD_STB_I), .wr_o(CMD_WR_I), .addr_o(CMD_ADDR_I),
    .data_o(CMD_DATA_I));

  rsdpc_top #(.POS_W(12), .TIMEOUT_MS(1), .CLK_KHZ(10)) i_rsdpc_top (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .CMD_STB_I(CMD_STB_I), .CMD_WR_I(CMD_WR_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I),
    .RPL_VALID_O(RPL_VALID_O), .RPL_DATA_O(RPL_DATA_O), .RPL_STATUS_O(RPL_STATUS_O), .RAW_POS_I(RAW_POS_I),
    .SPEED_I(SPEED_I), .DIR_I(DIR_I), .KEYS_I(KEYS_I), .PERMIT_I(PERMIT_I), .QUAL_I(QUAL_I),
    .CPU_FAULT_I(CPU_FAULT_I), .PWR_FAULT_I(PWR_FAULT_I), .CABLE_FAULT_I(CABLE_FAULT_I), .MOTION_O(MOTION_O),
    .HEALTHY_O(HEALTHY_O),
    .SCREEN_O(SCREEN_O), .DISP_POS_O(DISP_POS_O), .DISP_AUX_O(DISP_AUX_O), .CURSOR_O(CURSOR_O),
    .LIM_SEL_O(LIM_SEL_O));

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge MCLK_I);
    #1;
  endtask

  // Notes the expected reply, then lets the controller model issue the command
  task automatic cmd(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] ed,
                     input logic [1:0] es);
    expq.push_back({es, ed});
    i_rsdpc_plc_model.command(wr, a, d);
  endtask

  // Holds a key long enough for the two-flop sync and edge detect
  task automatic press(input int k);
    KEYS_I[k] = 1'b1;
    step(4);
    KEYS_I[k] = 1'b0;
    step(2);
  endtask

  // Reply watcher: oldest note against each reply
  always @(posedge MCLK_I) begin
    if (RPL_VALID_O === 1'b1) begin
      if (expq.size() == 0) check(18'h3ffff, 18'h0, "reply without command");
      else check({RPL_STATUS_O, RPL_DATA_O}, expq.pop_front(), "reply");
    end
  end

  // Hang guard; the full run needs well under 2000 cycles
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      check(18'h1, 18'h0, "timeout");
      conclude();
    end
  end

  initial begin
    void'($urandom(14));
    step(5);
    RST_I = 1'b0;
    step(2);
    cmd(0, rsdpc_pkg::ADDR_SCALE, 16'h0, 16'h0167, rsdpc_pkg::RPL_OK);
    cmd(0, rsdpc_pkg::ADDR_SHIFT, 16'h0, 16'h0000, rsdpc_pkg::RPL_OK);
    cmd(0, rsdpc_pkg::ADDR_WIN_UPPER, 16'h0, rsdpc_pkg::UPPER_RESET, rsdpc_pkg::RPL_OK);
    cmd(0, rsdpc_pkg::ADDR_WIN_LOWER, 16'h0, rsdpc_pkg::LOWER_RESET, rsdpc_pkg::RPL_OK);
    foreach (sv[i]) cmd(1, rsdpc_pkg::ADDR_SCALE, sv[i], sv[i], (sv[i] < 16'h0013 || sv[i] > 16'h0fff) ?
      rsdpc_pkg::RPL_RANGE : rsdpc_pkg::RPL_OK);
    cmd(0, rsdpc_pkg::ADDR_SCALE, 16'h0, 16'h03e7, rsdpc_pkg::RPL_OK);
    cmd(1, rsdpc_pkg::ADDR_SHIFT, 16'h03e8, 16'h03e8, rsdpc_pkg::RPL_RANGE);
    cmd(1, rsdpc_pkg::ADDR_SHIFT, 16'h03e7, 16'h03e7, rsdpc_pkg::RPL_OK);
    cmd(1, rsdpc_pkg::ADDR_SCALE, 16'h01f4, 16'h01f4, rsdpc_pkg::RPL_OK);
    cmd(0, rsdpc_pkg::ADDR_SHIFT, 16'h0, 16'h01f4, rsdpc_pkg::RPL_OK);
    for (int a = 16'h80; a <= 16'h84; a += 2) cmd(1, 16'(a), 16'h0055, 16'h0055, rsdpc_pkg::RPL_BADREG);
    cmd(0, 16'h0086, 16'h0, 16'h0000, rsdpc_pkg::RPL_BADREG);
    SPEED_I = 16'h0004;
    cmd(1, rsdpc_pkg::ADDR_SCALE, 16'h0190, 16'h0190, rsdpc_pkg::RPL_MOVING);
    cmd(1, rsdpc_pkg::ADDR_SHIFT, 16'h0001, 16'h0001, rsdpc_pkg::RPL_MOVING);
    cmd(0, rsdpc_pkg::ADDR_SPEED, 16'h0, 16'h0004, rsdpc_pkg::RPL_OK);
    SPEED_I = 16'h0003;
    cmd(1, rsdpc_pkg::ADDR_SCALE, 16'h0167, 16'h0167, rsdpc_pkg::RPL_OK);
    cmd(1, rsdpc_pkg::ADDR_SHIFT, 16'h000a, 16'h000a, rsdpc_pkg::RPL_OK);
    // Random angles plus the top count, which wraps past a full turn
    for (int i = 0; i < 5; i++) begin
      RAW_POS_I = (i == 4) ? 12'hfff : 12'($urandom);
      DIR_I = 1'($urandom);
      step(4);
      s = 16'((((32'(RAW_POS_I) * 360) >> 12) + 10) % 360);
      cmd(0, rsdpc_pkg::ADDR_ANGLE, 16'h0, s, rsdpc_pkg::RPL_OK);
      check(DISP_POS_O, s, "position field");
    end
    lo = 16'($urandom_range(999, 1));
    hi = lo + 16'($urandom_range(998, 1));
    cmd(1, rsdpc_pkg::ADDR_WIN_UPPER, 16'h07d0, 16'h07d0, rsdpc_pkg::RPL_RANGE);
    cmd(1, rsdpc_pkg::ADDR_WIN_UPPER, hi, hi, rsdpc_pkg::RPL_OK);
    cmd(1, rsdpc_pkg::ADDR_WIN_LOWER, lo, lo, rsdpc_pkg::RPL_OK);
    foreach (sv[i]) begin
      SPEED_I = (i == 0) ? lo - 16'h1 : (i == 1) ? lo : (i == 2) ? hi : (i == 3) ? hi + 16'h1 : 16'h0;
      step(4);
      check(MOTION_O, (SPEED_I >= lo && SPEED_I <= hi), "motion");
    end
    press(0);
    check(SCREEN_O, rsdpc_pkg::SCR_DEFAULT, "mode without permit");
    PERMIT_I = 1'b1;
    press(4);
    check(SCREEN_O, rsdpc_pkg::SCR_DEFAULT, "recall");
    press(0);
    check(SCREEN_O, rsdpc_pkg::SCR_SCALE, "enter scale");
    PERMIT_I = 1'b0;
    press(1);
    cmd(0, rsdpc_pkg::ADDR_SCALE, 16'h0, 16'h0167, rsdpc_pkg::RPL_OK);
    PERMIT_I = 1'b1;
    press(1);
    cmd(0, rsdpc_pkg::ADDR_SCALE, 16'h0, 16'h0168, rsdpc_pkg::RPL_OK);
    press(0);
    check(SCREEN_O, rsdpc_pkg::SCR_SCALE, "mode without qualifier");
    QUAL_I = 1'b1;
    press(0);
    check(SCREEN_O, rsdpc_pkg::SCR_SHIFT, "enter shift");
    check(DISP_AUX_O, 16'h000a, "shift field");
    press(1);
    cmd(0, rsdpc_pkg::ADDR_SHIFT, 16'h0, 16'h000b, rsdpc_pkg::RPL_OK);
    press(0);
    check({CURSOR_O, LIM_SEL_O, SCREEN_O}, {2'b01, rsdpc_pkg::SCR_LIMITS}, "enter limits");
    press(1);
    check(LIM_SEL_O, 1'b0, "selector toggle");
    press(3);
    check(CURSOR_O, 1'b1, "cursor move");
    press(1);
    cmd(0, rsdpc_pkg::ADDR_WIN_LOWER, 16'h0, lo + 16'h1, rsdpc_pkg::RPL_OK);
    press(0);
    check(SCREEN_O, rsdpc_pkg::SCR_DEFAULT, "limits to default");
    press(0);
    step(15);
    check(SCREEN_O, rsdpc_pkg::SCR_DEFAULT, "idle timeout");
    SPEED_I = hi;
    for (int k = 0; k < 3; k++) begin
      {CPU_FAULT_I, PWR_FAULT_I, CABLE_FAULT_I} = 3'(1 << k);
      step(6);
      check({HEALTHY_O, MOTION_O, SCREEN_O}, {2'b00, rsdpc_pkg::SCR_FAULT}, "fault");
      {CPU_FAULT_I, PWR_FAULT_I, CABLE_FAULT_I} = 3'h0;
      step(6);
      check({HEALTHY_O, MOTION_O, SCREEN_O}, {2'b11, rsdpc_pkg::SCR_DEFAULT}, "fault cleared");
    end
    step(4);
    check(18'(expq.size()), 18'h0, "replies outstanding");
    conclude();
  end
endmodule
